// File: rtl/tsc_pkg.sv
package tsc_pkg;

    // Clock rate and batch delay time base.
    localparam int CLK_MHZ = 25;
    localparam int BATCH_UNIT_US = 1000;
    localparam int BATCH_UNIT_CYCLES = BATCH_UNIT_US * CLK_MHZ;
    localparam int TIMER_W = 24;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_SCAN_TEST_CONFIG = 8'h00;
    localparam logic [7:0] OFS_PREPROCESS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_MAIN_CONFIG = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_LOW_THRESHOLD = 8'h10;
    localparam logic [7:0] OFS_HIGH_THRESHOLD = 8'h14;
    localparam logic [7:0] OFS_TEMP_DATA = 8'h18;
    localparam logic [7:0] OFS_AUX_DATA = 8'h1C;

    // Reset values and writable bit masks.
    localparam logic [15:0] SCAN_TEST_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] PREPROCESS_CONFIG_RESET = 16'h0000;
    localparam logic [15:0] SCAN_TEST_CONFIG_MASK = 16'h0F07;
    localparam logic [15:0] PREPROCESS_CONFIG_MASK = 16'hFFDF;
    localparam logic [11:0] THRESHOLD_RESET = 12'h000;

    // Main configuration fields.
    localparam int MAIN_MODE_BIT = 0;
    localparam int MAIN_STOP_BIT = 1;
    localparam int MAIN_CODE_LSB = 4;

    // Test range codes.
    localparam logic [3:0] RANGE_LAST_VALID = 4'hB;
    localparam logic [3:0] RANGE_SHORT_TEST = 4'hF;

    // Zone detection codes.
    localparam logic [1:0] ZONE_OFF = 2'h0;
    localparam logic [1:0] ZONE_BELOW = 2'h1;
    localparam logic [1:0] ZONE_BETWEEN = 2'h2;
    localparam logic [1:0] ZONE_ABOVE = 2'h3;

    typedef struct packed {
        logic [3:0] rsvd_hi;
        logic [3:0] test_range_select;
        logic [4:0] rsvd_lo;
        logic [2:0] batch_delay_select;
    } tsc_scan_cfg_type;

    typedef struct packed {
        logic pin_select_high;
        logic pin_select_low;
        logic [1:0] filter_depth;
        logic [1:0] filter_window;
        logic [1:0] temperature_zone_select;
        logic [1:0] auxiliary_zone_select;
        logic rsvd;
        logic [4:0] filter_enable_bits;
    } tsc_pre_cfg_type;

    typedef struct packed {
        logic valid;
        logic is_aux;
        logic [11:0] value;
    } tsc_result_type;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_CONVERT = 2'b01,
        SCAN_WAIT = 2'b10
    } tsc_scan_state_type;

endpackage

// File: rtl/tsc_config_regs.sv
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
module tsc_config_regs
    import tsc_pkg::*;
#(
    parameter int BATCH_CYCLES = BATCH_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pen_down,
    input wire logic set_done,
    input wire logic conv_busy,
    input wire logic xyz_data_ready,
    input wire tsc_result_type result,
    output logic scan_start,
    output logic scan_active,
    output logic irq_data_pin,
    output logic short_test_select,
    output logic [3:0] test_range_select,
    output logic filter_bypass,
    output logic [4:0] filter_enable_bits
);

    tsc_scan_cfg_type scan_test_config;
    tsc_pre_cfg_type preprocess_config;
    logic scan_control_mode;
    logic [3:0] converter_function_code;
    logic [11:0] low_threshold;
    logic [11:0] high_threshold;
    logic [11:0] temp_data;
    logic [11:0] aux_data;
    logic temp_ready;
    logic aux_ready;
    logic dav_delayed;
    tsc_scan_state_type state;
    logic [TIMER_W-1:0] timer;

    logic wr_done;
    logic rd_done;
    logic addr_ok;
    logic stop_req;
    logic scan_enabled;
    logic any_dav;
    logic [TIMER_W-1:0] delay_load;
    logic [1:0] zone_sel;
    logic zone_ok;
    logic next_pin;
    logic [31:0] next_rdata;

    assign wr_done = ce && psel && penable && pready && pwrite;
    assign rd_done = ce && psel && penable && pready && !pwrite;
    assign stop_req = wr_done && paddr == OFS_MAIN_CONFIG && pwdata[MAIN_STOP_BIT];
    // Device-driven scans need the mode bit and an XY or XYZ function code.
    assign scan_enabled = scan_control_mode && converter_function_code[3:1] == 3'h0;
    assign delay_load = TIMER_W'(({29'h0, scan_test_config.batch_delay_select} + 32'h1)
        * BATCH_CYCLES);
    assign any_dav = temp_ready || aux_ready || xyz_data_ready;

    always_comb begin
        case (paddr)
            OFS_SCAN_TEST_CONFIG, OFS_PREPROCESS_CONFIG, OFS_MAIN_CONFIG, OFS_STATUS,
            OFS_LOW_THRESHOLD, OFS_HIGH_THRESHOLD, OFS_TEMP_DATA, OFS_AUX_DATA: begin
                addr_ok = 1'b1;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // Zone test on the processed, right-justified result.
    always_comb begin
        zone_sel = result.is_aux ? preprocess_config.auxiliary_zone_select
            : preprocess_config.temperature_zone_select;
        case (zone_sel)
            ZONE_OFF: begin
                zone_ok = 1'b1;
            end
            ZONE_BELOW: begin
                zone_ok = result.value < low_threshold;
            end
            ZONE_BETWEEN: begin
                zone_ok = result.value >= low_threshold && result.value <= high_threshold;
            end
            ZONE_ABOVE: begin
                zone_ok = result.value > high_threshold;
            end
            default: begin
                zone_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            OFS_SCAN_TEST_CONFIG: begin
                next_rdata = {16'h0000, scan_test_config};
            end
            OFS_PREPROCESS_CONFIG: begin
                next_rdata = {16'h0000, preprocess_config};
            end
            OFS_MAIN_CONFIG: begin
                next_rdata = {24'h00_0000, converter_function_code, 3'h0, scan_control_mode};
            end
            OFS_STATUS: begin
                next_rdata = {26'h000_0000, aux_ready, temp_ready, state == SCAN_WAIT,
                    scan_active, !conv_busy, pen_down};
            end
            OFS_LOW_THRESHOLD: begin
                next_rdata = {20'h0_0000, low_threshold};
            end
            OFS_HIGH_THRESHOLD: begin
                next_rdata = {20'h0_0000, high_threshold};
            end
            OFS_TEMP_DATA: begin
                next_rdata = {20'h0_0000, temp_data};
            end
            OFS_AUX_DATA: begin
                next_rdata = {20'h0_0000, aux_data};
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        case ({preprocess_config.pin_select_high, preprocess_config.pin_select_low})
            2'b00: begin
                next_pin = !pen_down && any_dav;
            end
            2'b10: begin
                next_pin = !pen_down;
            end
            default: begin
                next_pin = !dav_delayed;
            end
        endcase
    end

    // Bus answer: no wait states, data sampled in the setup phase.
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= psel && !penable && !pready;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            scan_test_config <= SCAN_TEST_CONFIG_RESET;
            preprocess_config <= PREPROCESS_CONFIG_RESET;
            scan_control_mode <= 1'b0;
            converter_function_code <= 4'h0;
            low_threshold <= THRESHOLD_RESET;
            high_threshold <= THRESHOLD_RESET;
        end else if (wr_done) begin
            case (paddr)
                OFS_SCAN_TEST_CONFIG: begin
                    scan_test_config <= pwdata[15:0] & SCAN_TEST_CONFIG_MASK;
                end
                OFS_PREPROCESS_CONFIG: begin
                    preprocess_config <= pwdata[15:0] & PREPROCESS_CONFIG_MASK;
                end
                OFS_MAIN_CONFIG: begin
                    scan_control_mode <= pwdata[MAIN_MODE_BIT];
                    converter_function_code <= pwdata[MAIN_CODE_LSB +: 4];
                end
                OFS_LOW_THRESHOLD: begin
                    low_threshold <= pwdata[11:0];
                end
                OFS_HIGH_THRESHOLD: begin
                    high_threshold <= pwdata[11:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Configuration steering outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            test_range_select <= 4'h0;
            short_test_select <= 1'b0;
            filter_bypass <= 1'b1;
            filter_enable_bits <= 5'h00;
        end else if (ce) begin
            test_range_select <= scan_test_config.test_range_select;
            short_test_select <= scan_test_config.test_range_select == RANGE_SHORT_TEST;
            filter_bypass <= preprocess_config.filter_depth == 2'h0
                && preprocess_config.filter_window == 2'h0;
            filter_enable_bits <= preprocess_config.filter_enable_bits;
        end
    end

    // Result storage gated by zone detection; set wins over a host read.
    always_ff @(posedge clk) begin
        if (rst) begin
            temp_data <= 12'h000;
            aux_data <= 12'h000;
            temp_ready <= 1'b0;
            aux_ready <= 1'b0;
        end else if (ce) begin
            if (rd_done && paddr == OFS_TEMP_DATA) begin
                temp_ready <= 1'b0;
            end
            if (rd_done && paddr == OFS_AUX_DATA) begin
                aux_ready <= 1'b0;
            end
            if (result.valid && zone_ok) begin
                if (result.is_aux) begin
                    aux_data <= result.value;
                    aux_ready <= 1'b1;
                end else begin
                    temp_data <= result.value;
                    temp_ready <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dav_delayed <= 1'b0;
            irq_data_pin <= 1'b1;
        end else if (ce) begin
            dav_delayed <= any_dav;
            irq_data_pin <= next_pin;
        end
    end

    // Batch-paced scan sequencer.
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SCAN_IDLE;
            timer <= '0;
            scan_start <= 1'b0;
            scan_active <= 1'b0;
        end else if (ce) begin
            scan_start <= 1'b0;
            if (timer != '0) begin
                timer <= timer - TIMER_W'(1);
            end
            if (stop_req || !scan_enabled) begin
                state <= SCAN_IDLE;
                scan_active <= 1'b0;
            end else begin
                case (state)
                    SCAN_IDLE: begin
                        if (pen_down) begin
                            state <= SCAN_CONVERT;
                            timer <= delay_load;
                            scan_start <= 1'b1;
                            scan_active <= 1'b1;
                        end
                    end
                    SCAN_CONVERT: begin
                        if (set_done && timer != '0) begin
                            state <= SCAN_WAIT;
                        end else if (set_done && pen_down) begin
                            timer <= delay_load;
                            scan_start <= 1'b1;
                        end else if (set_done) begin
                            state <= SCAN_IDLE;
                            scan_active <= 1'b0;
                        end
                    end
                    SCAN_WAIT: begin
                        if (timer == '0 && pen_down) begin
                            state <= SCAN_CONVERT;
                            timer <= delay_load;
                            scan_start <= 1'b1;
                        end else if (timer == '0) begin
                            state <= SCAN_IDLE;
                            scan_active <= 1'b0;
                        end
                    end
                    default: begin
                        state <= SCAN_IDLE;
                        scan_active <= 1'b0;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_SCAN_RSVD_ZERO: assert property (
        (scan_test_config & ~SCAN_TEST_CONFIG_MASK) == 16'h0000 && preprocess_config.rsvd == 1'b0)
        else $error("Reserved configuration bits are not zero.");

    AST_START_ON_TOUCH: assert property (
        ce && state == SCAN_IDLE && scan_enabled && !stop_req && pen_down
        |=> scan_start && state == SCAN_CONVERT && timer == $past(delay_load))
        else $error("Touch did not start a paced scan.");

    AST_WAIT_HOLD: assert property (
        ce && state == SCAN_WAIT && timer > TIMER_W'(1) && scan_enabled && !stop_req
        |=> state == SCAN_WAIT && !scan_start)
        else $error("Scan left the wait state before the delay expired.");

    AST_RESTART: assert property (
        ce && state == SCAN_WAIT && timer == '0 && pen_down && scan_enabled && !stop_req
        |=> scan_start && state == SCAN_CONVERT ##1 !scan_start)
        else $error("Next sample set did not start after the delay.");

    AST_STOP: assert property (
        ce && (stop_req || !scan_enabled) |=> state == SCAN_IDLE && !scan_active)
        else $error("Stop or mode change did not halt the scan.");

    AST_PIN_AND: assert property (
        ce && !rst && preprocess_config.pin_select_high == 1'b0
        && preprocess_config.pin_select_low == 1'b0
        |=> irq_data_pin == ($past(!pen_down) && $past(any_dav)))
        else $error("Pin does not show touch AND data ready.");

    AST_PIN_DAV: assert property (
        ce && !rst && preprocess_config.pin_select_low |=> irq_data_pin == !$past(dav_delayed))
        else $error("Pin does not show delayed data ready.");

    AST_PIN_TOUCH: assert property (
        ce && !rst && preprocess_config.pin_select_high && !preprocess_config.pin_select_low
        |=> irq_data_pin == !$past(pen_down))
        else $error("Pin does not show the touch interrupt.");

    AST_ZONE_DISCARD: assert property (
        ce && result.valid && !result.is_aux && !zone_ok && !(rd_done && paddr == OFS_TEMP_DATA)
        |=> temp_data == $past(temp_data) && temp_ready == $past(temp_ready))
        else $error("Rejected temperature result changed stored state.");

    AST_ZONE_ACCEPT: assert property (
        ce && result.valid && result.is_aux && preprocess_config.auxiliary_zone_select == ZONE_OFF
        |=> aux_ready && aux_data == $past(result.value))
        else $error("Unzoned auxiliary result was not stored.");

    AST_DAV_HOLD: assert property (
        temp_ready && !(rd_done && paddr == OFS_TEMP_DATA) |=> temp_ready)
        else $error("Temperature data ready dropped without a read.");

    COV_WAIT: cover property (state == SCAN_CONVERT ##1 state == SCAN_WAIT);
    COV_RESTART: cover property (state == SCAN_WAIT ##1 scan_start);
    COV_DISCARD: cover property (result.valid && !zone_ok);
    COV_SHORT: cover property (short_test_select);

endmodule

// File: tb/tsc_conv_model.sv
`timescale 1ns/1ns
module tsc_conv_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic scan_start,
    input wire logic [15:0] set_cycles,
    output logic set_done,
    output logic conv_busy
);
    logic [15:0] count;
    // Each start runs one sample set of set_cycles clocks, then pulses done.
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= 16'h0000;
            set_done <= 1'b0;
        end else begin
            set_done <= (count == 16'h0001);
            if (scan_start) begin
                count <= set_cycles;
            end else if (count != 16'h0000) begin
                count <= count - 16'h0001;
            end
        end
    end
    assign conv_busy = (count != 16'h0000);
endmodule

// File: tb/tsc_config_regs_tb.sv
`timescale 1ns/1ns
module tsc_config_regs_tb;
    import tsc_pkg::*;
    localparam int BC = 8;
    logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr, e, pen_down = 0, xyz_data_ready = 0, set_done, conv_busy;
    tsc_result_type result = '0;
    logic scan_start, scan_active, irq_data_pin, short_test_select, filter_bypass;
    logic [3:0] test_range_select;
    logic [4:0] filter_enable_bits;
    logic [15:0] set_cycles = 16'h0003;
    logic [31:0] seed = 32'h0001_1AB5;
    logic [11:0] prev [2];
    logic [11:0] v;
    int failures = 0, compares = 0, n, c, ex, ln;
    always #20 clk = ~clk;
    tsc_config_regs #(.BATCH_CYCLES(BC)) uut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pen_down(pen_down), .set_done(set_done),
        .conv_busy(conv_busy), .xyz_data_ready(xyz_data_ready), .result(result),
        .scan_start(scan_start), .scan_active(scan_active), .irq_data_pin(irq_data_pin),
        .short_test_select(short_test_select), .test_range_select(test_range_select),
        .filter_bypass(filter_bypass), .filter_enable_bits(filter_enable_bits));
    tsc_conv_model conv (.clk(clk), .rst(rst), .scan_start(scan_start),
        .set_cycles(set_cycles), .set_done(set_done), .conv_busy(conv_busy));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic zone_ok(input int z, input logic [11:0] x);
        return z == 0 || (z == 1 && x < 12'h100) || (z == 3 && x > 12'h200)
            || (z == 2 && x >= 12'h100 && x <= 12'h200);
    endfunction
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %b expected %b", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0000_0000);
        chk_val(r, exp, m);
    endtask
    task automatic wait_start(input int bound);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (scan_start !== 1'b1 && n < bound);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chk_rd(OFS_SCAN_TEST_CONFIG, 32'h0000_0000, "scan reset");
        chk_rd(OFS_PREPROCESS_CONFIG, 32'h0000_0000, "pre reset");
        chk_bit(filter_bypass, 1'b1, "bypass reset");
        chk_val(32'(filter_enable_bits), 32'h0000_0000, "enables reset");
        $display("test reset done");
        for (int i = 0; i < 20; i++) begin
            pwdata <= (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : xs();
            @(posedge clk);
            ex = pwdata;
            apb(1'b1, OFS_SCAN_TEST_CONFIG, ex);
            apb(1'b1, OFS_PREPROCESS_CONFIG, ex);
            chk_rd(OFS_SCAN_TEST_CONFIG, ex & 32'h0000_0F07, "scan rw");
            chk_rd(OFS_PREPROCESS_CONFIG, ex & 32'h0000_FFDF, "pre rw");
            chk_val(32'(test_range_select), (ex >> 8) & 32'hF, "range");
            chk_bit(short_test_select, ex[11:8] == 4'hF, "short");
            chk_bit(filter_bypass, ex[13:10] == 4'h0, "bypass");
            chk_val(32'(filter_enable_bits), ex & 32'h1F, "enables");
        end
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk_bit(e, 1'b1, "unmapped error");
        chk_val(r, 32'h0000_0000, "unmapped data");
        $display("test registers done");
        for (int k = 0; k < 16; k++) begin
            pen_down <= k[0];
            xyz_data_ready <= k[1];
            apb(1'b1, OFS_PREPROCESS_CONFIG, 32'(k >> 2) << 14);
            repeat (3) @(posedge clk);
            chk_bit(irq_data_pin, k[2] ? !k[1] : k[3] ? !k[0] : (!k[0] && k[1]), "pin");
        end
        pen_down <= 1'b0;
        xyz_data_ready <= 1'b0;
        $display("test pin done");
        apb(1'b1, OFS_LOW_THRESHOLD, 32'h0000_0100);
        apb(1'b1, OFS_HIGH_THRESHOLD, 32'h0000_0200);
        chk_rd(OFS_TEMP_DATA, 32'h0000_0000, "temp data reset");
        chk_rd(OFS_AUX_DATA, 32'h0000_0000, "aux data reset");
        prev[0] = 12'h000;
        prev[1] = 12'h000;
        for (int z = 0; z < 4; z++) begin
            apb(1'b1, OFS_PREPROCESS_CONFIG, 32'((z << 8) | (z << 6)));
            for (int i = 0; i < 8; i++) begin
                v = (i == 0) ? 12'h0FF : (i == 1) ? 12'h100 : (i == 2) ? 12'h200 :
                    (i == 3) ? 12'h201 : xs() & 32'h0000_0FFF;
                @(posedge clk);
                result <= '{valid: 1'b1, is_aux: i[0], value: v};
                @(posedge clk);
                result.valid <= 1'b0;
                apb(1'b0, OFS_STATUS, 32'h0000_0000);
                chk_bit(r[4 + i[0]], zone_ok(z, v), "ready flag");
                chk_bit(r[1], 1'b1, "not busy");
                if (zone_ok(z, v)) prev[i[0]] = v;
                chk_rd(i[0] ? OFS_AUX_DATA : OFS_TEMP_DATA, 32'(prev[i[0]]), "data");
                apb(1'b0, OFS_STATUS, 32'h0000_0000);
                chk_bit(r[4 + i[0]], 1'b0, "flag cleared");
            end
        end
        ce <= 1'b0;
        result <= '{valid: 1'b1, is_aux: 1'b0, value: 12'hFFF};
        @(posedge clk);
        result.valid <= 1'b0;
        ce <= 1'b1;
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk_bit(r[4], 1'b0, "ce freeze");
        $display("test zones done");
        for (int i = 0; i < 3; i++) begin
            c = (i == 2) ? 7 : i * 3;
            ex = (c + 1) * BC;
            ln = ex + 6;
            set_cycles <= 16'h0003;
            apb(1'b1, OFS_SCAN_TEST_CONFIG, 32'(c));
            apb(1'b1, OFS_MAIN_CONFIG, 32'((i & 1) << 4) | 32'h0000_0001);
            pen_down <= 1'b1;
            wait_start(50);
            chk_bit(n < 50, 1'b1, "first start");
            wait_start(200);
            chk_bit(n >= ex - 1 && n <= ex + 3, 1'b1, "batch gap");
            set_cycles <= 16'(ln);
            wait_start(200);
            apb(1'b0, OFS_STATUS, 32'h0000_0000);
            chk_bit(r[1], 1'b0, "busy");
            chk_bit(r[2], 1'b1, "active");
            wait_start(300);
            chk_bit(n >= ln - 3 && n <= ln + 4, 1'b1, "long gap");
            pen_down <= 1'b0;
            n = 0;
            while (scan_active === 1'b1 && n < 300) begin
                @(posedge clk);
                n++;
            end
            chk_bit(scan_active, 1'b0, "pen lift stop");
        end
        apb(1'b1, OFS_MAIN_CONFIG, 32'h0000_0001);
        pen_down <= 1'b1;
        wait_start(50);
        chk_bit(n < 50, 1'b1, "restart on touch");
        apb(1'b1, OFS_MAIN_CONFIG, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk_bit(scan_active, 1'b0, "stop bit");
        apb(1'b1, OFS_MAIN_CONFIG, 32'h0000_0021);
        wait_start(100);
        chk_bit(n >= 100, 1'b1, "other code idle");
        apb(1'b1, OFS_MAIN_CONFIG, 32'h0000_0011);
        wait_start(50);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_bit(scan_active, 1'b0, "reset stop");
        chk_rd(OFS_SCAN_TEST_CONFIG, 32'h0000_0000, "scan after reset");
        $display("test scan done");
        complete_run();
    end
endmodule
